// *** common/mds_params.svh ***
`ifndef MDS_PARAMS_SVH
`define MDS_PARAMS_SVH
// Register byte offsets
`define MDS_ADR_CTRL     8'h00
`define MDS_ADR_OVP      8'h04
`define MDS_ADR_THR      8'h08
`define MDS_ADR_SPEED    8'h0c
`define MDS_ADR_STATE    8'h10
`define MDS_ADR_IRQ_ST   8'h14
`define MDS_ADR_IRQ_EN   8'h18
`define MDS_ADR_IRQ_CLR  8'h1c
`define MDS_ADR_CLEAR    8'h20
// Control register fields
`define MDS_CTRL_OVP_MODE   0
`define MDS_CTRL_LOW_POWER  1
`define MDS_CTRL_SRC_LO     2
`define MDS_CTRL_SRC_HI     3
`define MDS_CTRL_STU_LO     4
`define MDS_CTRL_STU_HI     5
`define MDS_CTRL_RESET      6'h00
// Probe method code
`define MDS_STARTUP_PROBE   2'h2
// Serial full scale
`define MDS_SERIAL_FS       16'h7fff
// Probe timer overflow value
`define MDS_PROBE_MAX       12'hfff
// Rate dividers from 50 MHz
`define MDS_DIV_10M         14'h0005
`define MDS_DIV_1M          14'h0032
`define MDS_DIV_100K        14'h01f4
`define MDS_DIV_10K         14'h1388
// Sleep detect time in microseconds
`define MDS_DET_US          1000
`define MDS_CLK_MHZ         50
`endif

// *** common/mds_pkg.sv ***
`default_nettype none
package mds_pkg;
  typedef enum logic [1:0] {
    MDS_RUN     = 2'b00,
    MDS_STANDBY = 2'b01,
    MDS_SLEEP   = 2'b10
  } mds_mode_type;
  typedef enum logic [1:0] {
    MDS_P_IDLE  = 2'b00,
    MDS_P_RISE  = 2'b01,
    MDS_P_DECAY = 2'b10
  } mds_probe_type;
  typedef enum logic [1:0] {
    MDS_SRC_ANALOG = 2'b00,
    MDS_SRC_DUTY   = 2'b01,
    MDS_SRC_FREQ   = 2'b10,
    MDS_SRC_SERIAL = 2'b11
  } mds_src_type;
endpackage
`default_nettype wire

// *** src/mds_supervisor.sv ***
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mds_params.svh"
module mds_supervisor
  import mds_pkg::*;
#(
  parameter int DET_CYCLES = (`MDS_DET_US * `MDS_CLK_MHZ),
  parameter int SLEEP_CYCLES = (`MDS_DET_US * `MDS_CLK_MHZ),
  parameter logic [11:0] PROBE_MAX = `MDS_PROBE_MAX
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] supply_level,
  input  wire logic [15:0] speed_level,
  input  wire logic        speed_pin,
  input  wire logic        output_disable_pin,
  input  wire logic        probe_request,
  input  wire logic        probe_current_reached,
  input  wire logic        probe_current_zero,
  output logic             switches_hiz,
  output logic             sense_amp_en,
  output logic             regulator_en,
  output logic             charge_pump_en,
  output logic             serial_bus_en,
  output logic             irq
);
  localparam logic [31:0] DET_W   = 32'(DET_CYCLES);
  localparam logic [31:0] SLEEP_W = 32'(SLEEP_CYCLES);

  typedef struct packed {
    logic [31:0]   rdata;
    logic          ack;
    logic [5:0]    ctrl;
    logic [15:0]   ovp_limit;
    logic [15:0]   zthr;
    logic [15:0]   zhyst;
    logic [15:0]   serial_speed;
    logic [2:0]    drv_sync;
    logic [2:0]    pin_sync;
    logic          drv_off;
    logic          pin_hi;
    logic          ov_fault;
    logic          zero_cmd;
    mds_mode_type  mode;
    logic [31:0]   dcnt;
    mds_probe_type probe;
    logic [1:0]    rate;
    logic [13:0]   div;
    logic [11:0]   ptim;
    logic          rise_fault;
    logic          decay_fault;
    logic [4:0]    irq_st;
    logic [4:0]    irq_en;
  } mds_state_type;

  mds_state_type s_reg, s_next;

  function automatic logic [13:0] rate_div(input logic [1:0] r);
    case (r)
      2'd0:    rate_div = `MDS_DIV_10M;
      2'd1:    rate_div = `MDS_DIV_1M;
      2'd2:    rate_div = `MDS_DIV_100K;
      default: rate_div = `MDS_DIV_10K;
    endcase
  endfunction

  logic        wr;
  logic        rd;
  logic        over_v;
  logic        tick;
  logic        ovf;
  logic        serial_mode;
  logic [31:0] fs;
  logic [31:0] lvl;
  logic [47:0] lvl_sc;
  logic [47:0] en_thr;
  logic [47:0] ex_thr;
  logic [4:0]  ev;
  logic        clr_req;
  logic        drv_cmd_fault;
  logic        rate_fault;
  logic        probe_on;

  always_comb begin
    s_next        = s_reg;
    wr            = wb_cyc_i && wb_stb_i && wb_we_i && !s_reg.ack;
    rd            = wb_cyc_i && wb_stb_i && !wb_we_i && !s_reg.ack;
    serial_mode   = (s_reg.ctrl[`MDS_CTRL_SRC_HI:`MDS_CTRL_SRC_LO] == MDS_SRC_SERIAL);
    over_v        = supply_level > s_reg.ovp_limit;
    clr_req       = wr && (wb_adr_i == `MDS_ADR_CLEAR) && wb_sel_i[0] && wb_dat_i[0];
    probe_on      = (s_reg.ctrl[`MDS_CTRL_STU_HI:`MDS_CTRL_STU_LO] == `MDS_STARTUP_PROBE);
    tick          = (s_reg.div == 14'h0000);
    // Timer top is a parameter so a bench can shorten the slowest pass
    ovf           = tick && (s_reg.ptim == PROBE_MAX);
    rate_fault    = probe_request && (s_reg.probe != MDS_P_IDLE);
    drv_cmd_fault = s_reg.drv_off && !s_reg.zero_cmd && (s_reg.mode == MDS_RUN);
    ev            = '0;
    // Bus slave: one registered ack a cycle after the request, dropped the cycle after
    s_next.ack    = wb_cyc_i && wb_stb_i && !s_reg.ack;
    s_next.rdata  = '0;
    if (wr) begin
      case (wb_adr_i)
        `MDS_ADR_CTRL:    if (wb_sel_i[0]) s_next.ctrl = wb_dat_i[5:0];
        `MDS_ADR_OVP:     if (wb_sel_i[0]) s_next.ovp_limit = wb_dat_i[15:0];
        `MDS_ADR_THR:     begin
          s_next.zthr  = wb_dat_i[15:0];
          s_next.zhyst = wb_dat_i[31:16];
        end
        `MDS_ADR_SPEED:   s_next.serial_speed = wb_dat_i[15:0];
        `MDS_ADR_IRQ_EN:  s_next.irq_en = wb_dat_i[4:0];
        default:          s_next.rdata = '0;
      endcase
    end
    if (rd) begin
      case (wb_adr_i)
        `MDS_ADR_CTRL:   s_next.rdata = {26'h0, s_reg.ctrl};
        `MDS_ADR_OVP:    s_next.rdata = {16'h0, s_reg.ovp_limit};
        `MDS_ADR_THR:    s_next.rdata = {s_reg.zhyst, s_reg.zthr};
        `MDS_ADR_SPEED:  s_next.rdata = {16'h0, s_reg.serial_speed};
        `MDS_ADR_STATE:  s_next.rdata = {24'h0, s_reg.rise_fault, s_reg.decay_fault,
                                         s_reg.ov_fault, s_reg.drv_off, s_reg.mode,
                                         s_reg.probe};
        `MDS_ADR_IRQ_ST: s_next.rdata = {27'h0, s_reg.irq_st};
        `MDS_ADR_IRQ_EN: s_next.rdata = {27'h0, s_reg.irq_en};
        default:         s_next.rdata = '0;
      endcase
    end

    // Pin inputs: three stages, change accepted once last two agree
    s_next.drv_sync = {s_reg.drv_sync[1:0], output_disable_pin};
    s_next.pin_sync = {s_reg.pin_sync[1:0], speed_pin};
    if (s_reg.drv_sync[2] == s_reg.drv_sync[1]) s_next.drv_off = s_reg.drv_sync[2];
    if (s_reg.pin_sync[2] == s_reg.pin_sync[1]) s_next.pin_hi = s_reg.pin_sync[2];

    // Overvoltage
    if (over_v) begin
      if (!s_reg.ov_fault) ev[0] = 1'b1;
      s_next.ov_fault = 1'b1;
    end else if (s_reg.ctrl[`MDS_CTRL_OVP_MODE]) begin
      s_next.ov_fault = 1'b0;
    end else if (clr_req) begin
      s_next.ov_fault = 1'b0;
    end

    // Standby thresholds; serial scales by full scale code
    fs     = serial_mode ? {16'h0, `MDS_SERIAL_FS} : 32'h0000_ffff;
    lvl    = serial_mode ? {16'h0, s_reg.serial_speed} : {16'h0, speed_level};
    // Compare in units of 1/65536: truncating the product would move a bound
    lvl_sc = {lvl, 16'h0000};
    en_thr = 48'(s_reg.zthr) * 48'(fs);
    ex_thr = (48'(s_reg.zthr) + 48'(s_reg.zhyst)) * 48'(fs);
    if (lvl_sc < en_thr) s_next.zero_cmd = 1'b1;
    else if (lvl_sc > ex_thr) s_next.zero_cmd = 1'b0;

    // Mode machine; detect counter restarts when condition breaks
    case (s_reg.mode)
      MDS_RUN: begin
        s_next.dcnt = '0;
        if (s_reg.zero_cmd) s_next.mode = MDS_STANDBY;
      end
      MDS_STANDBY: begin
        if (!s_reg.zero_cmd) begin
          s_next.mode = MDS_RUN;
          s_next.dcnt = '0;
        end else if (s_reg.ctrl[`MDS_CTRL_LOW_POWER]) begin
          if (serial_mode ? (s_reg.serial_speed == 16'h0000 && !s_reg.pin_hi)
                          : !s_reg.pin_hi) begin
            if (s_reg.dcnt >= (serial_mode ? SLEEP_W : DET_W) - 32'd1) begin
              s_next.mode = MDS_SLEEP;
              s_next.dcnt = '0;
            end else s_next.dcnt = s_reg.dcnt + 32'd1;
          end else s_next.dcnt = '0;
        end else s_next.dcnt = '0;
      end
      MDS_SLEEP: begin
        if (s_reg.pin_hi) begin
          if (s_reg.dcnt >= DET_W - 32'd1) begin
            s_next.mode = MDS_STANDBY;
            s_next.dcnt = '0;
          end else s_next.dcnt = s_reg.dcnt + 32'd1;
        end else s_next.dcnt = '0;
      end
      default: s_next.mode = MDS_RUN;
    endcase

    // Probe timers: rise then decay, each tried at four rates
    s_next.div = tick ? rate_div(s_reg.rate) - 14'd1 : s_reg.div - 14'd1;
    case (s_reg.probe)
      MDS_P_IDLE: begin
        if (probe_request && probe_on) begin
          s_next.probe = MDS_P_RISE;
          s_next.rate  = 2'd0;
          s_next.ptim  = '0;
          s_next.div   = rate_div(2'd0) - 14'd1;
        end
      end
      MDS_P_RISE: begin
        if (probe_current_reached) begin
          s_next.probe = MDS_P_DECAY;
          s_next.rate  = 2'd0;
          s_next.ptim  = '0;
          s_next.div   = rate_div(2'd0) - 14'd1;
        end else if (ovf) begin
          if (s_reg.rate == 2'd3) begin
            s_next.rise_fault = 1'b1;
            ev[1]             = 1'b1;
            s_next.probe      = MDS_P_IDLE;
          end else begin
            s_next.rate = s_reg.rate + 2'd1;
            s_next.ptim = '0;
            s_next.div  = rate_div(s_reg.rate + 2'd1) - 14'd1;
          end
        end else if (tick) s_next.ptim = s_reg.ptim + 12'd1;
      end
      MDS_P_DECAY: begin
        if (probe_current_zero) s_next.probe = MDS_P_IDLE;
        else if (ovf) begin
          if (s_reg.rate == 2'd3) begin
            s_next.decay_fault = 1'b1;
            ev[2]              = 1'b1;
            s_next.probe       = MDS_P_IDLE;
          end else begin
            s_next.rate = s_reg.rate + 2'd1;
            s_next.ptim = '0;
            s_next.div  = rate_div(s_reg.rate + 2'd1) - 14'd1;
          end
        end else if (tick) s_next.ptim = s_reg.ptim + 12'd1;
      end
      default: s_next.probe = MDS_P_IDLE;
    endcase
    if (clr_req && !ev[1]) s_next.rise_fault = 1'b0;
    if (clr_req && !ev[2]) s_next.decay_fault = 1'b0;
    ev[3] = rate_fault;
    ev[4] = drv_cmd_fault;

    // Sticky status: a set in the same cycle wins over the clear
    if (wr && wb_adr_i == `MDS_ADR_IRQ_CLR) s_next.irq_st = s_reg.irq_st & ~wb_dat_i[4:0];
    s_next.irq_st = s_next.irq_st | ev;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg       <= '0;
      s_reg.ctrl  <= `MDS_CTRL_RESET;
      s_reg.mode  <= MDS_RUN;
      s_reg.probe <= MDS_P_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o = s_reg.rdata;
  assign wb_ack_o = s_reg.ack;
  assign irq      = |(s_reg.irq_st & s_reg.irq_en);
  // Sleep drops everything; standby keeps supplies and bus
  assign switches_hiz   = s_reg.ov_fault || s_reg.drv_off || s_reg.rise_fault
                          || s_reg.decay_fault || (s_reg.mode != MDS_RUN);
  assign sense_amp_en   = (s_reg.mode != MDS_SLEEP);
  assign regulator_en   = (s_reg.mode != MDS_SLEEP);
  assign charge_pump_en = (s_reg.mode != MDS_SLEEP);
  assign serial_bus_en  = (s_reg.mode != MDS_SLEEP);

  AST_OV_SET: assert property (@(posedge clk) disable iff (!rstn)
    (supply_level > s_reg.ovp_limit) |=> s_reg.ov_fault)
    else $error("overvoltage not flagged");
  AST_OV_LATCH: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.ov_fault && !s_reg.ctrl[`MDS_CTRL_OVP_MODE] && !clr_req |=> s_reg.ov_fault)
    else $error("latched overvoltage dropped");
  AST_OV_AUTO: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.ctrl[`MDS_CTRL_OVP_MODE] && !over_v && !$past(over_v) |=> !s_reg.ov_fault)
    else $error("auto recovery failed");
  AST_HIZ: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.ov_fault |-> switches_hiz)
    else $error("switches active in fault");
  AST_DRV: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.drv_sync[2] && s_reg.drv_sync[1] |=> switches_hiz)
    else $error("disable pin ignored");
  AST_RISE_FLT: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.probe == MDS_P_RISE && ovf && s_reg.rate == 2'd3 && !probe_current_reached
    |=> s_reg.rise_fault)
    else $error("rise timeout missed");
  AST_RATE_STEP: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.probe == MDS_P_RISE && ovf && s_reg.rate != 2'd3 && !probe_current_reached
    |=> s_reg.rate == $past(s_reg.rate) + 2'd1)
    else $error("rate not stepped");
  AST_DECAY_FLT: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.probe == MDS_P_DECAY && ovf && s_reg.rate == 2'd3 && !probe_current_zero
    |=> s_reg.decay_fault)
    else $error("decay timeout missed");
  AST_SLEEP_OFF: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.mode == MDS_SLEEP |-> !serial_bus_en && !charge_pump_en && switches_hiz)
    else $error("sleep left blocks on");
  AST_CLR_HELD: assert property (@(posedge clk) disable iff (!rstn)
    clr_req && over_v |=> s_reg.ov_fault)
    else $error("clear honoured during fault");
  AST_PROBE_START: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.probe == MDS_P_IDLE && probe_request && probe_on
    |=> s_reg.probe == MDS_P_RISE && s_reg.rate == 2'd0 && s_reg.ptim == 12'h000)
    else $error("probe did not start at fastest rate");
  AST_RATE_FLAG: assert property (@(posedge clk) disable iff (!rstn)
    rate_fault |=> s_reg.irq_st[3])
    else $error("early probe request not flagged");
  AST_DRV_CMD: assert property (@(posedge clk) disable iff (!rstn)
    drv_cmd_fault |=> s_reg.irq_st[4])
    else $error("command while disabled not flagged");
  AST_STANDBY_ON: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.mode == MDS_STANDBY |-> charge_pump_en && regulator_en && serial_bus_en)
    else $error("standby dropped supplies or bus");
  AST_DECAY_STEP: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.probe == MDS_P_DECAY && ovf && s_reg.rate != 2'd3 && !probe_current_zero
    |=> s_reg.rate == $past(s_reg.rate) + 2'd1)
    else $error("decay rate not stepped");
  AST_SLEEP_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    s_reg.mode == MDS_SLEEP && !s_reg.pin_hi |=> s_reg.mode == MDS_SLEEP)
    else $error("woke without pin high");
endmodule // mds_supervisor
`default_nettype wire

// *** tb/mds_mcu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mds_mcu_model (
  input  wire logic        clk,
  output logic             wb_cyc,
  output logic             wb_stb,
  output logic             wb_we,
  output logic [7:0]       wb_adr,
  output logic [3:0]       wb_sel,
  output logic [31:0]      wb_dat,
  input  wire logic [31:0] wb_rdat,
  input  wire logic        wb_ack,
  output logic [15:0]      speed_level,
  output logic             speed_pin
);
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
    speed_level = 16'hffff;
    speed_pin = 1'b1;
  end
  // Request held until ack is seen; only the bench watchdog ends a dead wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat <= d;
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask
  // Pin held at a level for as long as the caller waits
  task automatic speed(input logic [15:0] lvl, input logic pin);
    @(posedge clk);
    speed_level <= lvl;
    speed_pin   <= pin;
  endtask
endmodule // mds_mcu_model
`default_nettype wire

// *** tb/test_mds_supervisor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mds_params.svh"
module test_mds_supervisor;
  logic        clk, rstn, cyc, stb, we, ack, spin, doff, preq, prch, pzero;
  logic        hiz, amp, rge, cp, sbus, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [15:0] sup, slvl;
  int          mismatches, check_count;

  mds_supervisor #(.DET_CYCLES(20), .SLEEP_CYCLES(20), .PROBE_MAX(12'h003)) u_mds_supervisor (
    .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .supply_level(sup), .speed_level(slvl), .speed_pin(spin),
    .output_disable_pin(doff), .probe_request(preq), .probe_current_reached(prch),
    .probe_current_zero(pzero), .switches_hiz(hiz), .sense_amp_en(amp),
    .regulator_en(rge), .charge_pump_en(cp), .serial_bus_en(sbus), .irq(irq));
  mds_mcu_model u_mds_mcu_model (
    .clk(clk), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel),
    .wb_dat(wdat), .wb_rdat(rdat), .wb_ack(ack), .speed_level(slvl), .speed_pin(spin));

  always #10 clk = ~clk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_mds_mcu_model.bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, output logic [31:0] v);
    logic [31:0] r;
    u_mds_mcu_model.bus(1'b0, a, 32'h0, r);
    v = r & m;
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic t_reset();
    logic [31:0] v;
    chk({hiz, amp, rge, cp, sbus, irq}, 6'h1e);
    rd(`MDS_ADR_CTRL, 32'hffffffff, v);
    chk(v, 32'h0);
    wr(8'h24, 32'hffffffff);
    rd(8'h24, 32'hffffffff, v);
    chk(v, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_ovp_latch();
    logic [31:0] v;
    wr(`MDS_ADR_OVP, 32'h1000);
    wr(`MDS_ADR_IRQ_EN, 32'h1);
    @(posedge clk) sup <= 16'h1001;
    cyc_wait(3);
    chk(hiz, 1'b1);
    chk(irq, 1'b1);
    rd(`MDS_ADR_STATE, 32'h20, v);
    chk(v, 32'h20);
    wr(`MDS_ADR_CLEAR, 32'h1);
    cyc_wait(2);
    chk(hiz, 1'b1);
    @(posedge clk) sup <= 16'h0800;
    cyc_wait(3);
    chk(hiz, 1'b1);
    wr(`MDS_ADR_CLEAR, 32'h1);
    cyc_wait(2);
    chk(hiz, 1'b0);
    wr(`MDS_ADR_IRQ_CLR, 32'h1);
    cyc_wait(2);
    chk(irq, 1'b0);
    $display("test ovp latched done");
  endtask
  task automatic t_ovp_auto();
    wr(`MDS_ADR_CTRL, 32'h1);
    @(posedge clk) sup <= 16'h1001;
    cyc_wait(3);
    chk(hiz, 1'b1);
    @(posedge clk) sup <= 16'h1000;
    cyc_wait(3);
    chk(hiz, 1'b0);
    wr(`MDS_ADR_CTRL, 32'h0);
    wr(`MDS_ADR_IRQ_CLR, 32'hff);
    $display("test ovp auto done");
  endtask
  task automatic t_output_disable_pin();
    wr(`MDS_ADR_IRQ_EN, 32'h10);
    @(posedge clk) doff <= 1'b1;
    cyc_wait(6);
    chk(hiz, 1'b1);
    chk(irq, 1'b1);
    @(posedge clk) doff <= 1'b0;
    cyc_wait(6);
    chk(hiz, 1'b0);
    wr(`MDS_ADR_IRQ_CLR, 32'h10);
    cyc_wait(2);
    chk(irq, 1'b0);
    wr(`MDS_ADR_IRQ_EN, 32'h0);
    $display("test output disable done");
  endtask
  // Levels just inside each bound, and one in the hysteresis band
  task automatic t_standby();
    logic [31:0] v;
    wr(`MDS_ADR_THR, 32'h1000_4000);
    for (int s = 0; s < 3; s++) begin
      wr(`MDS_ADR_CTRL, 32'(s) << 2);
      u_mds_mcu_model.speed(16'h3fff, 1'b1);
      cyc_wait(3);
      rd(`MDS_ADR_STATE, 32'hc, v);
      chk(v, 32'h4);
      chk({amp, rge, cp, sbus}, 4'hf);
      u_mds_mcu_model.speed(16'h4800, 1'b1);
      cyc_wait(3);
      rd(`MDS_ADR_STATE, 32'hc, v);
      chk(v, 32'h4);
      u_mds_mcu_model.speed(16'h5001, 1'b1);
      cyc_wait(3);
      rd(`MDS_ADR_STATE, 32'hc, v);
      chk(v, 32'h0);
    end
    u_mds_mcu_model.speed(16'hffff, 1'b1);
    wr(`MDS_ADR_SPEED, 32'h1ffe);
    wr(`MDS_ADR_CTRL, 32'hc);
    rd(`MDS_ADR_STATE, 32'hc, v);
    chk(v, 32'h4);
    wr(`MDS_ADR_SPEED, 32'h27ff);
    rd(`MDS_ADR_STATE, 32'hc, v);
    chk(v, 32'h4);
    wr(`MDS_ADR_SPEED, 32'h2800);
    rd(`MDS_ADR_STATE, 32'hc, v);
    chk(v, 32'h0);
    $display("test standby done");
  endtask
  // No bus traffic while asleep: the serial bus is off then
  task automatic t_sleep();
    logic [31:0] v;
    wr(`MDS_ADR_CTRL, 32'h2);
    u_mds_mcu_model.speed(16'h0000, 1'b0);
    cyc_wait(10);
    chk({amp, rge, cp, sbus}, 4'hf);
    cyc_wait(20);
    chk({hiz, amp, rge, cp, sbus}, 5'h10);
    u_mds_mcu_model.speed(16'hffff, 1'b1);
    cyc_wait(30);
    chk({amp, rge, cp, sbus}, 4'hf);
    wr(`MDS_ADR_SPEED, 32'h0);
    wr(`MDS_ADR_CTRL, 32'he);
    cyc_wait(30);
    chk({amp, rge, cp, sbus}, 4'hf);
    u_mds_mcu_model.speed(16'h0000, 1'b0);
    cyc_wait(30);
    chk({amp, rge, cp, sbus}, 4'h0);
    u_mds_mcu_model.speed(16'hffff, 1'b1);
    cyc_wait(30);
    chk({amp, rge, cp, sbus}, 4'hf);
    wr(`MDS_ADR_CTRL, 32'h0);
    cyc_wait(5);
    rd(`MDS_ADR_STATE, 32'hc, v);
    chk(v, 32'h0);
    $display("test sleep done");
  endtask
  task automatic t_probe();
    logic [31:0] v;
    wr(`MDS_ADR_CTRL, 32'h20);
    wr(`MDS_ADR_IRQ_EN, 32'h8);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) preq <= 1'b1;
      @(posedge clk) preq <= 1'b0;
      cyc_wait(2);
      rd(`MDS_ADR_STATE, 32'h3, v);
      chk(v, 32'h1);
    end
    chk(irq, 1'b1);
    @(posedge clk) prch <= 1'b1;
    cyc_wait(3);
    rd(`MDS_ADR_STATE, 32'h3, v);
    chk(v, 32'h2);
    @(posedge clk) pzero <= 1'b1;
    cyc_wait(3);
    rd(`MDS_ADR_STATE, 32'hc3, v);
    chk(v, 32'h0);
    chk(hiz, 1'b0);
    $display("test probe done");
  endtask
  // Timer top 3: four ticks per rate, so one full timeout is about 22220 cycles
  task automatic t_probe_timeout();
    logic [31:0] v;
    @(posedge clk) {prch, pzero} <= 2'b00;
    wr(`MDS_ADR_IRQ_CLR, 32'h1f);
    wr(`MDS_ADR_IRQ_EN, 32'h6);
    @(posedge clk) preq <= 1'b1;
    @(posedge clk) preq <= 1'b0;
    cyc_wait(22000);
    rd(`MDS_ADR_STATE, 32'hc3, v);
    chk(v, 32'h1);
    chk(irq, 1'b0);
    cyc_wait(300);
    rd(`MDS_ADR_STATE, 32'hc3, v);
    chk(v, 32'h80);
    chk({hiz, irq}, 2'h3);
    wr(`MDS_ADR_CLEAR, 32'h1);
    wr(`MDS_ADR_IRQ_CLR, 32'h2);
    chk({hiz, irq}, 2'h0);
    @(posedge clk) {preq, prch} <= 2'b11;
    @(posedge clk) preq <= 1'b0;
    cyc_wait(22000);
    rd(`MDS_ADR_STATE, 32'hc3, v);
    chk(v, 32'h2);
    cyc_wait(300);
    rd(`MDS_ADR_STATE, 32'hc3, v);
    chk(v, 32'h40);
    chk({hiz, irq}, 2'h3);
    wr(`MDS_ADR_CLEAR, 32'h1);
    cyc_wait(2);
    chk(hiz, 1'b0);
    $display("test probe timeout done");
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {sup, doff, preq, prch, pzero} = '0;
    mismatches = 0;
    check_count = 0;
    cyc_wait(2);
    rstn <= 1'b1;
    cyc_wait(5);
    t_reset();
    t_ovp_latch();
    t_ovp_auto();
    t_output_disable_pin();
    t_standby();
    t_sleep();
    t_probe();
    t_probe_timeout();
    test_done();
  end
  // Whole run needs about 45000 cycles, mostly the two slow probe timeouts
  initial begin
    cyc_wait(60000);
    mismatches++;
    test_done();
  end
endmodule // test_mds_supervisor
`default_nettype wire
